// ===== include/bmsp_pkg.sv
// Shared constants for the boot-mode serial programmer.
// Assumes one 50 MHz system clock and an 8N1 asynchronous host link.
package bmsp_pkg;
  // Mode strap codes {mode_pin_b, mode_pin_a}
  localparam logic [1:0] STRAP_BOOT = 2'h2;
  localparam logic [1:0] STRAP_UPROG = 2'h1;
  localparam logic [1:0] STRAP_DELAY = 2'h3;   // Cycles after reset before straps are caught
  // Frame layout
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] RX_STOP_IDX = 4'h9;
  localparam logic [3:0] TX_LAST_IDX = 4'h9;
  localparam logic [3:0] PRESCALE_LAST = 4'h8;  // Low run of H'00 is 9 bit times
  // Rate limits for the automatic rate search
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BAUD_SLOW = 9600;
  localparam int unsigned BAUD_FAST = 19200;
  // Byte values on the link
  localparam logic [7:0] BYTE_SYNC = 8'h00;
  localparam logic [7:0] BYTE_ECHO = 8'h55;
  localparam logic [7:0] BYTE_ACK = 8'h06;
  localparam logic [7:0] BYTE_NAK = 8'h15;
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  localparam logic [7:0] BLOCK_END = 8'hff;
  // Inquiry commands
  localparam logic [7:0] CMD_INQ_SIZE = 8'h20;
  localparam logic [7:0] CMD_INQ_ORG = 8'h21;
  localparam logic [7:0] CMD_INQ_START = 8'h22;
  localparam logic [7:0] CMD_INQ_SUPPORT = 8'h23;
  localparam logic [7:0] CMD_INQ_END = 8'h40;
  // Working commands
  localparam logic [7:0] CMD_PROG_PREP = 8'h43;
  localparam logic [7:0] CMD_ERASE_PREP = 8'h48;
  localparam logic [7:0] CMD_CHECKSUM = 8'h4b;
  localparam logic [7:0] CMD_BLANK = 8'h4d;
  localparam logic [7:0] CMD_STATUS = 8'h4f;
  localparam logic [7:0] CMD_READ = 8'h52;
  localparam logic [7:0] CMD_PROG = 8'h50;
  localparam logic [7:0] CMD_ERASE = 8'h58;
  // Inquiry answers and the end address of programming
  localparam logic [7:0] ARRAY_START = 8'h00;
  localparam logic [7:0] SUPPORT_CODE = 8'h01;
  localparam logic [31:0] ADDR_END = 32'hffffffff;
  // Sequencer states
  typedef enum logic [14:0] {
    ST_IDLE = 15'h0001, ST_BAUD = 15'h0002, ST_SYNC = 15'h0004,
    ST_ECHO = 15'h0008, ST_INQ = 15'h0010, ST_WIPE = 15'h0020,
    ST_CMD = 15'h0040, ST_PWAIT = 15'h0080, ST_PADDR = 15'h0100,
    ST_PDATA = 15'h0200, ST_EWAIT = 15'h0400, ST_EBLK = 15'h0800,
    ST_RADDR = 15'h1000, ST_SUM = 15'h2000, ST_REPLY = 15'h4000
  } bmsp_state_t;
endpackage : bmsp_pkg

// ===== logic/bmsp_boot_mode_serial_programmer.sv
// Boot-mode serial programmer: mode strap decode, rate search, 8N1 link,
// command sequencer with an embedded byte array, and the reply FIFO.
// Assumes a single clock, pins arriving asynchronously and a host tool.
`timescale 1ns/1ps

// Plain synchronous FIFO with valid/ready on both sides
module bmsp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             doPush;
  logic             doPop;

  // Full and empty come straight from the occupancy count
  // Count is one bit wider than the pointers, so DEPTH itself fits in it
  assign inReady  = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = store[rdPtr_reg];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // Storage is written only, never reset
  always_ff @(posedge clk) begin
    if (doPush) begin
      store[wrPtr_reg] <= inData;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule : bmsp_fifo

module bmsp_boot_mode_serial_programmer
  import bmsp_pkg::*;
#(
  parameter int unsigned MEM_DEPTH = 256,
  parameter int unsigned BLK_SHIFT = 5,
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned MIN_BIT_CYC = (CLK_HZ / BAUD_FAST) * 7 / 8,
  parameter int unsigned MAX_BIT_CYC = (CLK_HZ / BAUD_SLOW) * 9 / 8
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic modePinA,
  input  wire logic modePinB,
  input  wire logic nmiPin,
  input  wire logic irqPin,
  input  wire logic rxdPin,
  output logic      txdPin,
  output logic      irqOut,
  output logic      bootModeOut,
  output logic      userBootModeOut,
  output logic      userProgModeOut,
  output logic      ramRoutineRunOut
);
  localparam int unsigned AW = $clog2(MEM_DEPTH);
  localparam int unsigned BLOCKS = MEM_DEPTH >> BLK_SHIFT;

  // Synchronisers: stage 1 feeds stage 2 only
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       modeA;
  logic       modeB;
  logic       nmiS;
  logic       irqS;
  logic       rxS;
  assign {modeA, modeB, nmiS, irqS, rxS} = sync2_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 5'h1f;
      sync2_reg <= 5'h1f;
    end else begin
      sync1_reg <= {modePinA, modePinB, nmiPin, irqPin, rxdPin};
      sync2_reg <= sync1_reg;
    end
  end

  // Straps are caught a few cycles after release, once synchronised
  logic [1:0] strapCnt_reg;
  logic       bootMode_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strapCnt_reg     <= '0;
      bootMode_reg     <= 1'b0;
      bootModeOut      <= 1'b0;
      userBootModeOut  <= 1'b0;
      userProgModeOut  <= 1'b0;
      ramRoutineRunOut <= 1'b0;
    end else if (strapCnt_reg != STRAP_DELAY) begin
      strapCnt_reg <= strapCnt_reg + 1'b1;
      if (strapCnt_reg == STRAP_DELAY - 1'b1) begin
        bootMode_reg     <= ({modeB, modeA} == STRAP_BOOT) && nmiS;
        bootModeOut      <= ({modeB, modeA} == STRAP_BOOT) && nmiS;
        userBootModeOut  <= ({modeB, modeA} == STRAP_BOOT) && !nmiS;
        userProgModeOut  <= ({modeB, modeA} == STRAP_UPROG);
        ramRoutineRunOut <= ({modeB, modeA} == STRAP_UPROG);
      end
    end
  end

  // Interrupts pass through once the straps are caught, except in boot mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= irqS && !bootMode_reg && (strapCnt_reg == STRAP_DELAY);
    end
  end

  bmsp_state_t state_reg;

  // Rate search: count low time in units of nine clock cycles
  logic [3:0]  preCnt_reg;
  logic [15:0] runCnt_reg;
  logic [15:0] lastRun_reg;
  logic [15:0] bitCyc_reg;
  logic        rxPrev_reg;
  logic        locked_reg;
  logic [15:0] runDiff;
  assign runDiff = (runCnt_reg > lastRun_reg) ? runCnt_reg - lastRun_reg
                                              : lastRun_reg - runCnt_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      preCnt_reg  <= '0;
      runCnt_reg  <= '0;
      lastRun_reg <= '0;
      bitCyc_reg  <= 16'hffff;
      rxPrev_reg  <= 1'b1;
      locked_reg  <= 1'b0;
    end else begin
      rxPrev_reg <= rxS;
      if (state_reg == ST_BAUD) begin
        if (!rxS) begin
          preCnt_reg <= (preCnt_reg == PRESCALE_LAST) ? '0 : preCnt_reg + 1'b1;
          if (preCnt_reg == PRESCALE_LAST && runCnt_reg != 16'hffff) begin
            runCnt_reg <= runCnt_reg + 1'b1;
          end
        end else if (!rxPrev_reg) begin
          preCnt_reg  <= '0;
          runCnt_reg  <= '0;
          lastRun_reg <= runCnt_reg;
          // only rates in the guaranteed band lock
          if (runCnt_reg >= 16'(MIN_BIT_CYC) && runCnt_reg <= 16'(MAX_BIT_CYC)
              && runDiff <= 16'h0001) begin
            bitCyc_reg <= runCnt_reg;
            locked_reg <= 1'b1;
          end
        end
      end
    end
  end

  // Receiver, 8N1, enabled once the rate is locked
  logic [15:0] rxCnt_reg;
  logic [3:0]  rxBit_reg;
  logic [7:0]  rxShift_reg;
  logic        rxBusy_reg;
  logic        rxValid_reg;
  logic [7:0]  rxData_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxCnt_reg   <= '0;
      rxBit_reg   <= '0;
      rxShift_reg <= '0;
      rxBusy_reg  <= 1'b0;
      rxValid_reg <= 1'b0;
      rxData_reg  <= '0;
    end else begin
      rxValid_reg <= 1'b0;
      if (!rxBusy_reg) begin
        if (locked_reg && !rxS) begin
          rxBusy_reg <= 1'b1;
          rxCnt_reg  <= bitCyc_reg >> 1;
          rxBit_reg  <= '0;
        end
      end else if (rxCnt_reg != '0) begin
        rxCnt_reg <= rxCnt_reg - 1'b1;
      end else begin
        rxCnt_reg <= bitCyc_reg - 1'b1;
        rxBit_reg <= rxBit_reg + 1'b1;
        // start, 8 data LSB first, stop
        if (rxBit_reg == '0) begin
          rxBusy_reg <= !rxS;  // Glitch rather than a start bit
        end else if (rxBit_reg != RX_STOP_IDX) begin
          rxShift_reg <= {rxS, rxShift_reg[DATA_BITS-1:1]};
        end else begin
          rxBusy_reg  <= 1'b0;
          rxValid_reg <= rxS;   // Framing error drops the byte
          rxData_reg  <= rxShift_reg;
        end
      end
    end
  end

  // Reply FIFO between the sequencer and the transmitter
  logic [7:0] pushData;
  logic       pushValid;
  logic       pushReady;
  logic [7:0] popData;
  logic       popValid;
  logic       popReady;
  bmsp_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) replyFifo (
    .clk      (clk),
    .reset    (reset),
    .inData   (pushData),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .outData  (popData),
    .outValid (popValid),
    .outReady (popReady)
  );

  // Transmitter drains the FIFO one frame at a time
  logic [15:0] txCnt_reg;
  logic [3:0]  txBit_reg;
  logic [8:0]  txShift_reg;
  logic        txBusy_reg;
  assign popReady = !txBusy_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txCnt_reg   <= '0;
      txBit_reg   <= '0;
      txShift_reg <= 9'h1ff;
      txBusy_reg  <= 1'b0;
      txdPin      <= 1'b1;
    end else if (!txBusy_reg) begin
      if (popValid) begin
        txBusy_reg  <= 1'b1;
        txdPin      <= 1'b0;
        txShift_reg <= {1'b1, popData};
        txCnt_reg   <= bitCyc_reg - 1'b1;
        txBit_reg   <= '0;
      end
    end else if (txCnt_reg != '0) begin
      txCnt_reg <= txCnt_reg - 1'b1;
    end else begin
      txCnt_reg <= bitCyc_reg - 1'b1;
      txBit_reg <= txBit_reg + 1'b1;
      if (txBit_reg == TX_LAST_IDX) begin
        txBusy_reg <= 1'b0;
      end else begin
        txdPin      <= txShift_reg[0];
        txShift_reg <= {1'b1, txShift_reg[8:1]};
      end
    end
  end

  // Embedded array: data plus a written flag per byte
  logic [7:0]           mem [MEM_DEPTH];
  logic [MEM_DEPTH-1:0] written_reg;

  // Unwritten bytes read as erased, hiding stale contents
  function automatic logic [7:0] bmsp_visible(input logic wr, input logic [7:0] d);
    bmsp_visible = wr ? d : BYTE_ERASED;
  endfunction : bmsp_visible

  // Sequencer registers
  bmsp_state_t retState_reg;
  logic [7:0]  reply_reg;
  logic [31:0] addr_reg;
  logic [1:0]  addrIdx_reg;
  logic [AW-1:0] scan_reg;
  logic [7:0]  sum_reg;
  logic        lastNak_reg;
  logic        wipeAll;
  logic        eraseBlk;
  logic        progByte;
  logic        inRange;
  logic [31:0] addrNext;
  assign pushValid = (state_reg == ST_REPLY);
  assign pushData  = reply_reg;
  assign addrNext  = {addr_reg[23:0], rxData_reg};
  assign inRange   = (addrNext < 32'(MEM_DEPTH));
  assign wipeAll   = (state_reg == ST_WIPE);
  assign eraseBlk  = (state_reg == ST_EBLK) && rxValid_reg && rxData_reg < 8'(BLOCKS);
  assign progByte  = (state_reg == ST_PDATA) && rxValid_reg
                     && !written_reg[addr_reg[AW-1:0]];

  // Byte storage, written only by programming
  always_ff @(posedge clk) begin
    if (progByte) begin
      mem[addr_reg[AW-1:0]] <= rxData_reg;
    end
  end

  // Written flags: wipe and block erase clear, programming sets
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      written_reg <= '0;
    end else begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        if (wipeAll) begin
          written_reg[i] <= 1'b0;
        end else if (eraseBlk && (i >> BLK_SHIFT) == int'(rxData_reg)) begin
          written_reg[i] <= 1'b0;
        end else if (progByte && i == int'(addr_reg[AW-1:0])) begin
          written_reg[i] <= 1'b1;
        end
      end
    end
  end

  // Main sequencer; every answer goes through ST_REPLY and the FIFO
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      retState_reg <= ST_IDLE;
      reply_reg    <= '0;
      addr_reg     <= '0;
      addrIdx_reg  <= '0;
      scan_reg     <= '0;
      sum_reg      <= '0;
      lastNak_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (bootMode_reg) begin
            state_reg <= ST_BAUD;
          end
        end
        ST_BAUD: begin
          if (locked_reg) begin
            state_reg <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          reply_reg    <= BYTE_SYNC;
          retState_reg <= ST_ECHO;
          state_reg    <= ST_REPLY;
        end
        ST_ECHO: begin
          // wait for H'55, stray H'00 bytes dropped
          if (rxValid_reg && rxData_reg == BYTE_ECHO) begin
            state_reg <= ST_INQ;
          end
        end
        ST_INQ: begin
          if (rxValid_reg) begin
            retState_reg <= ST_INQ;
            state_reg    <= ST_REPLY;
            case (rxData_reg)
              CMD_INQ_SIZE:    reply_reg <= 8'(AW);
              CMD_INQ_ORG:     reply_reg <= 8'(BLOCKS);
              CMD_INQ_START:   reply_reg <= ARRAY_START;
              CMD_INQ_SUPPORT: reply_reg <= SUPPORT_CODE;
              CMD_INQ_END:     state_reg <= ST_WIPE;
              default:         reply_reg <= BYTE_NAK;
            endcase
          end
        end
        ST_WIPE: begin
          reply_reg    <= BYTE_ACK;
          retState_reg <= ST_CMD;
          state_reg    <= ST_REPLY;
        end
        ST_CMD: begin
          if (rxValid_reg) begin
            retState_reg <= ST_CMD;
            state_reg    <= ST_REPLY;
            reply_reg    <= BYTE_ACK;
            case (rxData_reg)
              CMD_PROG_PREP:  retState_reg <= ST_PWAIT;
              CMD_ERASE_PREP: retState_reg <= ST_EWAIT;
              CMD_BLANK:      reply_reg <= (written_reg == '0) ? BYTE_ACK : BYTE_NAK;
              CMD_STATUS:     reply_reg <= {7'h00, lastNak_reg};
              CMD_READ:       state_reg <= ST_RADDR;
              CMD_CHECKSUM: begin
                state_reg <= ST_SUM;
                scan_reg  <= '0;
                sum_reg   <= '0;
              end
              default:        reply_reg <= BYTE_NAK;
            endcase
          end
        end
        ST_PWAIT: begin
          if (rxValid_reg) begin
            addrIdx_reg <= '0;
            state_reg   <= (rxData_reg == CMD_PROG) ? ST_PADDR : ST_PWAIT;
          end
        end
        ST_PADDR: begin
          if (rxValid_reg) begin
            addr_reg    <= addrNext;
            addrIdx_reg <= addrIdx_reg + 1'b1;
            if (addrIdx_reg == 2'h3) begin
              state_reg <= ST_REPLY;
              if (addrNext == ADDR_END) begin
                reply_reg    <= BYTE_ACK;
                retState_reg <= ST_CMD;
              end else if (inRange) begin
                state_reg <= ST_PDATA;
              end else begin
                reply_reg    <= BYTE_NAK;
                retState_reg <= ST_PWAIT;
              end
            end
          end
        end
        ST_PDATA: begin
          if (rxValid_reg) begin
            reply_reg    <= progByte ? BYTE_ACK : BYTE_NAK;
            lastNak_reg  <= !progByte;
            retState_reg <= ST_PWAIT;
            state_reg    <= ST_REPLY;
          end
        end
        ST_EWAIT: begin
          if (rxValid_reg) begin
            state_reg <= (rxData_reg == CMD_ERASE) ? ST_EBLK : ST_EWAIT;
          end
        end
        ST_EBLK: begin
          if (rxValid_reg) begin
            state_reg    <= ST_REPLY;
            retState_reg <= ST_EWAIT;
            reply_reg    <= eraseBlk ? BYTE_ACK : BYTE_NAK;
            if (rxData_reg == BLOCK_END) begin
              reply_reg    <= BYTE_ACK;
              retState_reg <= ST_CMD;
            end
          end
        end
        ST_RADDR: begin
          if (rxValid_reg) begin
            reply_reg    <= bmsp_visible(written_reg[rxData_reg[AW-1:0]],
                                         mem[rxData_reg[AW-1:0]]);
            retState_reg <= ST_CMD;
            state_reg    <= ST_REPLY;
          end
        end
        ST_SUM: begin
          sum_reg  <= sum_reg + bmsp_visible(written_reg[scan_reg], mem[scan_reg]);
          scan_reg <= scan_reg + 1'b1;
          if (scan_reg == AW'(MEM_DEPTH - 1)) begin
            reply_reg    <= sum_reg + bmsp_visible(written_reg[scan_reg], mem[scan_reg]);
            retState_reg <= ST_CMD;
            state_reg    <= ST_REPLY;
          end
        end
        ST_REPLY: begin
          // Full FIFO stalls the sequencer here
          if (pushReady) begin
            state_reg <= retState_reg;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule : bmsp_boot_mode_serial_programmer

// ===== dv/bmsp_properties.sv
// Checker on the programmer's top ports: strap decode, interrupt gating, link framing.
// Assumes straps stay fixed from each reset until the next one.
`timescale 1ns/1ps
module bmsp_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic modePinA,
  input wire logic modePinB,
  input wire logic nmiPin,
  input wire logic irqPin,
  input wire logic rxdPin,
  input wire logic txdPin,
  input wire logic irqOut,
  input wire logic bootModeOut,
  input wire logic userBootModeOut,
  input wire logic userProgModeOut,
  input wire logic ramRoutineRunOut
);
  logic [3:0] relCnt_reg;
  logic       settled;

  // Cycles since reset release; mode outputs are trusted only after the strap catch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      relCnt_reg <= 4'h0;
    end else if (relCnt_reg != 4'hf) begin
      relCnt_reg <= relCnt_reg + 4'h1;
    end
  end
  assign settled = (relCnt_reg >= 4'h4);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Steady interrupt input outside boot mode, and the first cycle of a sent frame
  sequence sIrqHigh; (settled && !bootModeOut && irqPin)[*5]; endsequence
  sequence sIrqLow; (settled && !bootModeOut && !irqPin)[*5]; endsequence
  sequence sStartBit; $fell(txdPin) ##0 bootModeOut; endsequence

  a_boot_decode: assert property (settled |->
    bootModeOut == (modePinB && !modePinA && nmiPin)) else $error("boot mode decode wrong");
  a_uboot_decode: assert property (settled |->
    userBootModeOut == (modePinB && !modePinA && !nmiPin)) else $error("user boot decode wrong");
  a_uprog_decode: assert property (settled |->
    userProgModeOut == (!modePinB && modePinA)) else $error("user program decode wrong");
  a_ram_routine: assert property (ramRoutineRunOut == userProgModeOut)
    else $error("RAM routine flag differs from user program mode");
  a_irq_blocked: assert property (settled && bootModeOut |-> !irqOut)
    else $error("interrupt passed in boot mode");
  a_irq_pass: assert property (sIrqHigh |-> irqOut)
    else $error("interrupt not passed outside boot mode");
  a_irq_drop: assert property (sIrqLow |-> !irqOut)
    else $error("interrupt output stuck high");
  a_start_bit: assert property (sStartBit |-> !txdPin [*7])
    else $error("start bit too short");
  a_quiet_link: assert property (settled && !bootModeOut |-> txdPin)
    else $error("serial output active outside boot mode");
endmodule : bmsp_checker

bind bmsp_boot_mode_serial_programmer bmsp_checker bmsp_checker_i (
  .clk(clk), .reset(reset), .modePinA(modePinA), .modePinB(modePinB), .nmiPin(nmiPin),
  .irqPin(irqPin), .rxdPin(rxdPin), .txdPin(txdPin), .irqOut(irqOut),
  .bootModeOut(bootModeOut), .userBootModeOut(userBootModeOut),
  .userProgModeOut(userProgModeOut), .ramRoutineRunOut(ramRoutineRunOut)
);

// ===== dv/bmsp_host_model.sv
// Host tool model: 8N1 sender and receiver on the boot link.
// Assumes a fixed bit time in clock cycles; its line changes 1 ns after clk rises.
`timescale 1ns/1ps
module bmsp_host_model #(
  parameter int unsigned BIT = 16
) (
  input  wire logic clk,
  input  wire logic devTxd,
  output logic      hostTxd
);
  // Idle line is high between frames
  initial hostTxd = 1'b1;

  // start bit, eight data bits LSB first, one stop bit
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1 hostTxd = frame[i];
      repeat (BIT - 1) @(posedge clk);
    end
  endtask : sendByte

  // sample on falling edges so device updates have settled
  task automatic getByte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (devTxd !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n < 20000) begin
      repeat (BIT / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge clk);
        b[i] = devTxd;
      end
      repeat (BIT) @(negedge clk);
      ok = (devTxd === 1'b1);
    end
  endtask : getByte
endmodule : bmsp_host_model

// ===== dv/bmsp_tb.sv
// Testbench: strap decode, interrupt gating and the boot-mode host dialogue.
// Assumes the host bit time of 16 cycles lies inside the shortened rate window.
`timescale 1ns/1ps
module tb;
  import bmsp_pkg::*;
  localparam int unsigned MEM   = 256;
  localparam int unsigned LIMIT = 60000;
  localparam int unsigned HOLD  = 5000;   // 100 us of reset at 20 ns a cycle
  logic clk;
  logic reset;
  logic modePinA;
  logic modePinB;
  logic nmiPin;
  logic irqPin;
  logic rxdPin;
  logic txdPin;
  logic irqOut;
  logic bootModeOut;
  logic userBootModeOut;
  logic userProgModeOut;
  logic ramRoutineRunOut;
  int   numErrors = 0;
  int   numChecks = 0;
  int   cycles    = 0;

  // Rate window shortened so a 16-cycle bit locks quickly
  bmsp_boot_mode_serial_programmer #(.MEM_DEPTH(MEM), .BLK_SHIFT(5), .FIFO_DEPTH(16),
    .MIN_BIT_CYC(8), .MAX_BIT_CYC(64)) bmsp_boot_mode_serial_programmer_i (
    .clk(clk), .reset(reset), .modePinA(modePinA), .modePinB(modePinB), .nmiPin(nmiPin),
    .irqPin(irqPin), .rxdPin(rxdPin), .txdPin(txdPin), .irqOut(irqOut),
    .bootModeOut(bootModeOut), .userBootModeOut(userBootModeOut),
    .userProgModeOut(userProgModeOut), .ramRoutineRunOut(ramRoutineRunOut));

  bmsp_host_model #(.BIT(16)) bmsp_host_model_i (
    .clk(clk), .devTxd(txdPin), .hostTxd(rxdPin));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard; a hit counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      numErrors++;
      $display("[ERR] timeout expected done seen running");
      wrapUp();
    end
  end

  task automatic wrapUp();
    $display("errors %0d checks %0d", numErrors, numChecks);
    if (numErrors == 0 && numChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrapUp

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Inputs move and outputs are read 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Straps are held through reset and well past the catch point
  // Resets fall only between flash jobs, never during programming or erasing
  task automatic doReset(input logic [2:0] strap);
    step(1);
    reset = 1'b1;
    {modePinB, modePinA, nmiPin} = strap;
    step(HOLD);
    reset = 1'b0;
    step(5);
  endtask : doReset

  // Send n bytes, high byte first, while listening for the one reply
  task automatic txrx(input logic [47:0] bytes, input int n, input logic [7:0] exp,
                      input string what);
    logic [7:0] got;
    logic       ok;
    fork
      for (int i = n - 1; i >= 0; i--) bmsp_host_model_i.sendByte(bytes[8*i +: 8]);
      bmsp_host_model_i.getByte(got, ok);
    join
    chk({what, "Stop"}, 8'h01, {7'h00, ok});
    chk(what, exp, got);
  endtask : txrx

  // Straps 2 to 5 of {modePinB, modePinA, nmiPin} from the mode table, ending in boot mode
  // no routine is loaded into RAM here, so none can overlap it
  task automatic testModes();
    logic [2:0] s;
    for (int k = 2; k < 6; k++) begin
      s = k[2:0];
      doReset(s);
      chk("modes", {4'h0, s == 3'h5, s == 3'h4, !s[2], !s[2]},
          {4'h0, bootModeOut, userBootModeOut, userProgModeOut, ramRoutineRunOut});
      irqPin = 1'b1;
      step(8);
      chk("irqHigh", {7'h00, s != 3'h5}, {7'h00, irqOut});
      irqPin = 1'b0;
      step(8);
      chk("irqLow", 8'h00, {7'h00, irqOut});
    end
  endtask : testModes

  task automatic testSync();
    logic [7:0] inq [5];
    logic [7:0] ans [5];
    inq = '{CMD_INQ_SIZE, CMD_INQ_ORG, CMD_INQ_START, CMD_INQ_SUPPORT, CMD_INQ_END};
    ans = '{8'($clog2(MEM)), 8'(MEM >> 5), ARRAY_START, SUPPORT_CODE, BYTE_ACK};
    txrx(48'h0, 3, BYTE_SYNC, "rateLock");
    bmsp_host_model_i.sendByte(BYTE_ECHO);
    for (int k = 0; k < 5; k++) txrx(48'(inq[k]), 1, ans[k], "inquiry");
    txrx(48'(CMD_BLANK), 1, BYTE_ACK, "blankAfterWipe");
    txrx(48'({CMD_READ, 8'h05}), 2, BYTE_ERASED, "readAfterWipe");
  endtask : testSync

  task automatic testProgram();
    txrx(48'(CMD_PROG_PREP), 1, BYTE_ACK, "progPrep");
    txrx({CMD_PROG, 32'h5, 8'ha5}, 6, BYTE_ACK, "progByte");
    txrx(48'({CMD_PROG, ADDR_END}), 5, BYTE_ACK, "progEnd");
    txrx(48'({CMD_READ, 8'h05}), 2, 8'ha5, "readBack");
    txrx(48'(CMD_CHECKSUM), 1, 8'((MEM - 1) * 255 + 'ha5), "checksum");
    txrx(48'(CMD_BLANK), 1, BYTE_NAK, "blankUsed");
    txrx(48'(CMD_STATUS), 1, 8'h00, "statusOk");
    txrx(48'(CMD_PROG_PREP), 1, BYTE_ACK, "progPrep2");
    txrx(48'({CMD_PROG, 32'h100}), 5, BYTE_NAK, "progRange");
    txrx({CMD_PROG, 32'h5, 8'h5a}, 6, BYTE_NAK, "rewrite");
    txrx(48'({CMD_PROG, ADDR_END}), 5, BYTE_ACK, "progEnd2");
    txrx(48'(CMD_STATUS), 1, 8'h01, "statusRefused");
  endtask : testProgram

  task automatic testErase();
    txrx(48'(CMD_ERASE_PREP), 1, BYTE_ACK, "erasePrep");
    txrx(48'({CMD_ERASE, 8'h08}), 2, BYTE_NAK, "eraseRange");
    txrx(48'({CMD_ERASE, 8'h00}), 2, BYTE_ACK, "eraseBlock");
    txrx(48'({CMD_ERASE, BLOCK_END}), 2, BYTE_ACK, "eraseEnd");
    txrx(48'({CMD_READ, 8'h05}), 2, BYTE_ERASED, "readErased");
    txrx(48'(CMD_BLANK), 1, BYTE_ACK, "blankAgain");
  endtask : testErase

  // Main sequence
  initial begin
    reset = 1'b1;
    {modePinB, modePinA, nmiPin} = 3'h5;
    irqPin = 1'b0;
    step(10);
    testModes();
    testSync();
    testProgram();
    testErase();
    wrapUp();
  end
endmodule : tb
